// file: src/flash_host_pkg.sv
package flash_host_pkg;

    // Widths of the flash pins and of the internal counters
    localparam int ADDR_W      = 17;
    localparam int DATA_W      = 8;
    localparam int CNT_W       = 24;
    localparam int STEP_W      = 4;
    localparam int NUM_BLOCKS  = 8;
    localparam int BLOCK_SHIFT = 14;

    // Status bit positions in a byte read back during an automatic operation
    localparam int TOGGLE_POS = 6;
    localparam int POLL_POS   = 7;

    // Command bytes written to the device command register
    localparam logic [DATA_W-1:0] CMD_READ_MODE    = 8'h00;
    localparam logic [DATA_W-1:0] CMD_PROG_SETUP   = 8'h40;
    localparam logic [DATA_W-1:0] CMD_CHIP_ERASE   = 8'h20;
    localparam logic [DATA_W-1:0] CMD_BLOCK_ERASE  = 8'h60;
    localparam logic [DATA_W-1:0] CMD_ERASE_VERIFY = 8'ha0;
    localparam logic [DATA_W-1:0] CMD_RESET        = 8'hff;
    localparam logic [DATA_W-1:0] ERASED_BYTE      = 8'hff;

    // Times in their own units and the derived cycle counts at 10 MHz
    localparam int CLK_KHZ         = 10000;
    localparam int WE_LOW_NS       = 50;
    localparam int READ_ACCESS_NS  = 120;
    localparam int VPP_SETUP_NS    = 100;
    localparam int VERIFY_SETUP_US = 6;
    localparam int BLOCK_GAP_MS    = 30;
    localparam logic [CNT_W-1:0] WE_LOW_CYC =
        CNT_W'((WE_LOW_NS * CLK_KHZ + 999999) / 1000000);
    localparam logic [CNT_W-1:0] READ_CYC =
        CNT_W'((READ_ACCESS_NS * CLK_KHZ + 999999) / 1000000);
    localparam logic [CNT_W-1:0] VPP_CYC =
        CNT_W'((VPP_SETUP_NS * CLK_KHZ + 999999) / 1000000);
    localparam logic [CNT_W-1:0] VERIFY_CYC =
        CNT_W'((VERIFY_SETUP_US * CLK_KHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] BLOCK_GAP_CYC = CNT_W'(BLOCK_GAP_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] POLL_LIMIT_DEF = 24'hf42400;

    // Operations that the user side may request
    typedef enum logic [2:0] {
        OP_READ, OP_READ_MODE, OP_PROGRAM, OP_CHIP_ERASE,
        OP_BLOCK_ERASE, OP_VERIFY, OP_RESET
    } op_t;

    typedef enum logic [3:0] {
        S_IDLE, S_VPP, S_ISSUE, S_WR_LO, S_WR_HI, S_WAIT, S_RD, S_EVAL, S_DONE
    } st_t;

    // One user request
    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [NUM_BLOCKS-1:0] blocks;
    } req_t;

    // Flash pins driven by the controller
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe;
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              vpp_en;
    } pins_t;

    // Whole state of the controller
    typedef struct packed {
        st_t                   st;
        op_t                   op;
        logic [STEP_W-1:0]     step;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     data;
        logic [NUM_BLOCKS-1:0] mask;
        logic [DATA_W-1:0]     rdata;
        logic [DATA_W-1:0]     prev;
        logic                  have_prev;
        logic [CNT_W-1:0]      cnt;
        logic [CNT_W-1:0]      polls;
        logic                  fail;
        pins_t                 pins;
    } state_t;

    localparam pins_t PINS_IDLE = '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1,
                                    oe_n: 1'b1, we_n: 1'b1, vpp_en: 1'b0};
    localparam state_t STATE_RESET = '{st: S_IDLE, op: OP_READ, step: '0, addr: '0,
                                       data: '0, mask: '0, rdata: '0, prev: '0,
                                       have_prev: 1'b0, cnt: '0, polls: '0,
                                       fail: 1'b0, pins: PINS_IDLE};

endpackage

// file: src/flash_command_host.sv
// Behaviour
// R1 - Write 40H to enter program set-up before the program data write.
// R2 - Next write after set-up starts programming; address on fall, data on rise.
// R3 - Program ends when toggle bit is still twice and both status bits match data.
// R4 - Chip erase needs 20H written twice in succession.
// R5 - Device erases only with programming voltage high.
// R6 - Block erase needs 60H written twice, second enters block loading.
// R7 - Eight block flags selected by the three top address bits.
// R8 - First block address captured on the second write strobe fall.
// R9 - Each further block write within 30ms; expiry starts the erase.
// R10 - Block erase complete when polling bit reads one.
// R11 - Write A0H with the byte address to start erase verify.
// R12 - Verify returns FFH only when the whole byte is erased.
// R13 - Host reissues verify command before each byte it checks.
// R14 - On a failed byte host erases again and resumes from that address; this host only sets fail and leaves the re-erase to the user side.
// R15 - Verify mode lasts until another valid command is written.
// R16 - Two FFH writes after a set-up abort without changing the array.
// R17 - After a failure host resets with two FFH writes, then a command.
// R18 - Toggle bit inverts on each read while an operation runs.
// R19 - Status bits valid from the second write strobe rise onward.
// R20 - During programming polling bit reads complement of written bit.
// R21 - During erase polling bit reads zero until erase completes.
// R22 - Device powers up read-only; changes need a full two-step sequence.
// R23 - Programming voltage low forces command 00H and read-only operation.
// R24 - Writing 00H selects array read mode until the command changes.
`timescale 1ns/1ps
module flash_command_host #(
    parameter logic [flash_host_pkg::CNT_W-1:0] BLOCK_WAIT = flash_host_pkg::BLOCK_GAP_CYC,
    parameter logic [flash_host_pkg::CNT_W-1:0] POLL_LIMIT = flash_host_pkg::POLL_LIMIT_DEF
) (
    // Clock and reset
    input  wire logic                                mclk,
    input  wire logic                                rstn,
    // User request port
    input  wire logic                                req_valid,
    input  wire flash_host_pkg::req_t                req,
    output logic                                     req_ready,
    output logic                                     done,
    output logic                                     fail,
    output logic [flash_host_pkg::DATA_W-1:0]        rdata,
    // Flash pins
    output flash_host_pkg::pins_t                    pins,
    input  wire logic [flash_host_pkg::DATA_W-1:0]   dq_in
);

    flash_host_pkg::state_t                  s;
    flash_host_pkg::state_t                  n;
    logic                                    wr_go;
    logic                                    rd_go;
    logic [flash_host_pkg::DATA_W-1:0]       wr_byte;
    logic [flash_host_pkg::ADDR_W-1:0]       wr_addr;
    logic [2:0]                              low_idx;
    logic                                    stable;
    logic                                    finished;

    // Outputs straight from the state register
    assign pins      = s.pins;
    assign rdata     = s.rdata;
    assign fail      = s.fail;
    assign done      = (s.st == flash_host_pkg::S_DONE);
    assign req_ready = (s.st == flash_host_pkg::S_IDLE);

    // Next-state logic of the command sequencer
    always_comb begin
        n        = s;
        wr_go    = 1'b0;
        rd_go    = 1'b0;
        wr_byte  = flash_host_pkg::CMD_READ_MODE;
        wr_addr  = s.addr;
        low_idx  = 3'h0;
        // Lowest block still to be loaded
        for (int i = flash_host_pkg::NUM_BLOCKS - 1; i >= 0; i--) begin
            if (s.mask[i]) begin
                low_idx = 3'(i);
            end
        end
        stable   = s.have_prev && // R18
                   (s.rdata[flash_host_pkg::TOGGLE_POS] == s.prev[flash_host_pkg::TOGGLE_POS]);
        finished = 1'b0;
        case (s.op)
            flash_host_pkg::OP_PROGRAM: finished = stable && (s.rdata[7:6] == s.data[7:6]); // R3
            flash_host_pkg::OP_CHIP_ERASE: finished = stable && s.rdata[flash_host_pkg::POLL_POS];
            default: finished = s.rdata[flash_host_pkg::POLL_POS]; // R10
        endcase
        case (s.st)
            flash_host_pkg::S_IDLE: begin
                if (req_valid) begin
                    n.op        = req.op;
                    n.addr      = req.addr;
                    n.data      = req.data;
                    n.mask      = req.blocks;
                    n.step      = '0;
                    n.fail      = 1'b0;
                    n.have_prev = 1'b0;
                    n.polls     = '0;
                    if (req.op == flash_host_pkg::OP_READ) begin
                        rd_go = 1'b1;
                    end else if (req.op == flash_host_pkg::OP_BLOCK_ERASE && req.blocks == '0) begin
                        n.fail = 1'b1;
                        n.st   = flash_host_pkg::S_DONE;
                    end else begin
                        // Raise programming voltage before any command write
                        n.pins.vpp_en = 1'b1; // R5
                        n.cnt         = flash_host_pkg::VPP_CYC - 1'b1;
                        n.st          = flash_host_pkg::S_VPP;
                    end
                end
            end
            flash_host_pkg::S_VPP: begin
                if (s.cnt == '0) begin
                    n.st = flash_host_pkg::S_ISSUE;
                end else begin
                    n.cnt = s.cnt - 1'b1;
                end
            end
            flash_host_pkg::S_ISSUE: begin
                n.step = s.step + 4'h1;
                case (s.op)
                    flash_host_pkg::OP_PROGRAM: begin
                        if (s.step == 4'h0) begin
                            wr_go   = 1'b1;
                            wr_byte = flash_host_pkg::CMD_PROG_SETUP; // R1
                        end else if (s.step == 4'h1) begin
                            wr_go   = 1'b1;
                            wr_byte = s.data; // R2
                        end else begin
                            rd_go = 1'b1;
                        end
                    end
                    flash_host_pkg::OP_CHIP_ERASE: begin
                        if (s.step < 4'h2) begin
                            wr_go   = 1'b1;
                            wr_byte = flash_host_pkg::CMD_CHIP_ERASE; // R4
                        end else begin
                            rd_go = 1'b1;
                        end
                    end
                    flash_host_pkg::OP_BLOCK_ERASE: begin
                        wr_byte = flash_host_pkg::CMD_BLOCK_ERASE; // R6
                        wr_addr = {low_idx, {flash_host_pkg::BLOCK_SHIFT{1'b0}}}; // R7 R8
                        if (s.step == 4'h0) begin
                            wr_go = 1'b1;
                        end else if (s.mask != '0) begin
                            // Block writes follow back to back, well inside the gap
                            wr_go           = 1'b1; // R9
                            n.mask[low_idx] = 1'b0;
                            n.step          = 4'h2;
                        end else begin
                            // Let the loading period expire before polling
                            n.cnt = BLOCK_WAIT - 1'b1; // R9
                            n.st  = flash_host_pkg::S_WAIT;
                        end
                    end
                    flash_host_pkg::OP_VERIFY: begin
                        if (s.step == 4'h0) begin
                            wr_go   = 1'b1;
                            wr_byte = flash_host_pkg::CMD_ERASE_VERIFY; // R11 R13
                        end else begin
                            n.cnt = flash_host_pkg::VERIFY_CYC - 1'b1;
                            n.st  = flash_host_pkg::S_WAIT;
                        end
                    end
                    flash_host_pkg::OP_RESET: begin
                        if (s.step < 4'h2) begin
                            wr_go   = 1'b1;
                            wr_byte = flash_host_pkg::CMD_RESET; // R16
                        end else begin
                            n.st = flash_host_pkg::S_DONE;
                        end
                    end
                    flash_host_pkg::OP_READ_MODE: begin
                        if (s.step == 4'h0) begin
                            wr_go   = 1'b1;
                            wr_byte = flash_host_pkg::CMD_READ_MODE; // R24
                        end else begin
                            n.st = flash_host_pkg::S_DONE;
                        end
                    end
                    default: n.st = flash_host_pkg::S_DONE;
                endcase
            end
            flash_host_pkg::S_WR_LO: begin
                if (s.cnt == '0) begin
                    n.pins.we_n = 1'b1;
                    n.st        = flash_host_pkg::S_WR_HI;
                end else begin
                    n.cnt = s.cnt - 1'b1;
                end
            end
            flash_host_pkg::S_WR_HI: begin
                // Data held one cycle past the strobe rise, then released
                n.pins.ce_n  = 1'b1;
                n.pins.dq_oe = 1'b0;
                n.st         = flash_host_pkg::S_ISSUE;
            end
            flash_host_pkg::S_WAIT: begin
                if (s.cnt == '0) begin
                    rd_go = 1'b1;
                end else begin
                    n.cnt = s.cnt - 1'b1;
                end
            end
            flash_host_pkg::S_RD: begin
                if (s.cnt == '0) begin
                    n.rdata     = dq_in;
                    n.pins.oe_n = 1'b1;
                    n.pins.ce_n = 1'b1;
                    n.st        = flash_host_pkg::S_EVAL;
                end else begin
                    n.cnt = s.cnt - 1'b1;
                end
            end
            flash_host_pkg::S_EVAL: begin
                case (s.op)
                    flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_CHIP_ERASE,
                    flash_host_pkg::OP_BLOCK_ERASE: begin
                        n.prev      = s.rdata;
                        n.have_prev = 1'b1;
                        if (finished) begin // R19 R20 R21
                            n.st = flash_host_pkg::S_DONE;
                        end else if (s.polls == POLL_LIMIT) begin
                            // Failure: abort with the reset pair
                            n.fail = 1'b1; // R17
                            n.op   = flash_host_pkg::OP_RESET;
                            n.step = '0;
                            n.st   = flash_host_pkg::S_ISSUE;
                        end else begin
                            n.polls = s.polls + 1'b1;
                            rd_go   = 1'b1;
                        end
                    end
                    flash_host_pkg::OP_VERIFY: begin
                        n.fail = (s.rdata != flash_host_pkg::ERASED_BYTE); // R12
                        n.st   = flash_host_pkg::S_DONE;
                    end
                    default: n.st = flash_host_pkg::S_DONE;
                endcase
            end
            flash_host_pkg::S_DONE: begin
                n.pins.vpp_en = 1'b0; // R15 R23
                n.st          = flash_host_pkg::S_IDLE;
            end
            default: n = flash_host_pkg::STATE_RESET;
        endcase
        // Start of a write strobe: address with falling edge, data held to rise
        if (wr_go) begin
            n.pins.addr   = wr_addr;
            n.pins.dq_out = wr_byte;
            n.pins.dq_oe  = 1'b1;
            n.pins.ce_n   = 1'b0;
            n.pins.oe_n   = 1'b1;
            n.pins.we_n   = 1'b0;
            n.cnt         = flash_host_pkg::WE_LOW_CYC - 1'b1;
            n.st          = flash_host_pkg::S_WR_LO;
        end
        // Start of a read cycle
        if (rd_go) begin
            n.pins.addr  = n.addr;
            n.pins.dq_oe = 1'b0;
            n.pins.ce_n  = 1'b0;
            n.pins.oe_n  = 1'b0;
            n.pins.we_n  = 1'b1;
            n.cnt        = flash_host_pkg::READ_CYC - 1'b1;
            n.st         = flash_host_pkg::S_RD;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s <= flash_host_pkg::STATE_RESET; // R22
        end else begin
            s <= n;
        end
    end

    // Helper history of written bytes for the checks below
    logic [7:0]                        hist0;
    logic [7:0]                        hist1;
    logic [flash_host_pkg::ADDR_W-1:0] haddr;
    logic [flash_host_pkg::CNT_W-1:0]  gap;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hist0 <= 8'h00;
            hist1 <= 8'h00;
            haddr <= '0;
            gap   <= '0;
        end else if (s.st == flash_host_pkg::S_WR_HI) begin
            hist1 <= hist0;
            hist0 <= s.pins.dq_out;
            haddr <= s.pins.addr;
            gap   <= '0;
        end else if (gap != '1) begin
            gap <= gap + 1'b1;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    prog_setup_a: assert property ((s.st == flash_host_pkg::S_WR_HI) && // R1
        (s.op == flash_host_pkg::OP_PROGRAM) && (s.step == 4'h2)
        |-> hist0 == flash_host_pkg::CMD_PROG_SETUP) else $error("program data without set-up");
    chip_twice_a: assert property ((s.st == flash_host_pkg::S_WR_HI) && // R4
        (s.op == flash_host_pkg::OP_CHIP_ERASE) && (s.step == 4'h2)
        |-> hist0 == flash_host_pkg::CMD_CHIP_ERASE &&
            s.pins.dq_out == flash_host_pkg::CMD_CHIP_ERASE) else $error("chip erase not twice");
    block_twice_a: assert property ((s.st == flash_host_pkg::S_WR_HI) && // R6
        (s.op == flash_host_pkg::OP_BLOCK_ERASE) && (s.step == 4'h2) && (hist1 != 8'h60)
        |-> hist0 == flash_host_pkg::CMD_BLOCK_ERASE) else $error("block erase not twice");
    block_gap_a: assert property ((s.st == flash_host_pkg::S_WR_HI) && // R9
        (s.op == flash_host_pkg::OP_BLOCK_ERASE) && (s.step == 4'h2)
        |-> gap < BLOCK_WAIT) else $error("block load gap too long");
    verify_addr_a: assert property ($rose(s.st == flash_host_pkg::S_RD) && // R11
        (s.op == flash_host_pkg::OP_VERIFY)
        |-> hist0 == flash_host_pkg::CMD_ERASE_VERIFY && haddr == s.pins.addr)
        else $error("verify read without verify command");
    verify_each_a: assert property ((s.st == flash_host_pkg::S_DONE) && // R13
        (s.op == flash_host_pkg::OP_VERIFY) |-> s.step == 4'h2 &&
        $past(s.st, 2) == flash_host_pkg::S_RD) else $error("verify not reissued");
    reset_pair_a: assert property ((s.st == flash_host_pkg::S_DONE) && // R16
        (s.op == flash_host_pkg::OP_RESET)
        |-> hist0 == flash_host_pkg::CMD_RESET && hist1 == flash_host_pkg::CMD_RESET)
        else $error("reset not two writes");
    fail_reset_a: assert property ((s.st == flash_host_pkg::S_EVAL) && n.fail && !s.fail // R17
        && (s.op != flash_host_pkg::OP_VERIFY) |=> s.op == flash_host_pkg::OP_RESET ##[1:20]
        (s.st == flash_host_pkg::S_DONE)) else $error("failure not followed by reset");
    read_mode_a: assert property ((s.st == flash_host_pkg::S_DONE) && // R24
        (s.op == flash_host_pkg::OP_READ_MODE) |-> hist0 == flash_host_pkg::CMD_READ_MODE)
        else $error("read mode not written");

    prog_done_c: cover property ((s.st == flash_host_pkg::S_DONE) &&
        (s.op == flash_host_pkg::OP_PROGRAM) && !s.fail);
    block_done_c: cover property ((s.st == flash_host_pkg::S_DONE) &&
        (s.op == flash_host_pkg::OP_BLOCK_ERASE) && !s.fail);
    verify_done_c: cover property ((s.st == flash_host_pkg::S_DONE) &&
        (s.op == flash_host_pkg::OP_VERIFY));
    timeout_c: cover property ((s.st == flash_host_pkg::S_DONE) && s.fail &&
        (s.op == flash_host_pkg::OP_RESET));

endmodule

// file: test/flash_device_model.sv
`timescale 1ns/1ps
module flash_device_model #(
    parameter int BUSY_READS = 5,
    parameter int GAP        = 15
) (
    // Controller side
    input  wire logic                         mclk,
    input  wire flash_host_pkg::pins_t        pins,
    input  wire logic                         hang,
    output logic [flash_host_pkg::DATA_W-1:0] dq_in
);
    logic [7:0]  mem [0:131071];
    logic [7:0]  flags, last, rd;
    logic [16:0] a_lat;
    logic [2:0]  st;
    logic        tog, prog;
    int          busy, gap;

    // Power-up in read mode with an erased array
    initial begin
        foreach (mem[k]) mem[k] = 8'hff;
        st = 3'd0;
        busy = 0;
        tog = 1'b0;
        flags = 8'h00;
        rd = 8'h00;
    end

    // Address and block flags are latched on the falling strobe
    always @(negedge pins.we_n) begin
        a_lat = pins.addr;
        if (st == 3'd3 || st == 3'd4) flags[pins.addr[16:14]] = 1'b1;
    end

    // Command decode on the rising strobe; low voltage blocks everything
    always @(posedge pins.we_n) begin
        if (!pins.vpp_en) st = 3'd0;
        else case (st)
            3'd1: begin
                if (pins.dq_out == 8'hff) st = 3'd6;
                else begin
                    mem[a_lat] = mem[a_lat] & pins.dq_out;
                    last = pins.dq_out;
                    prog = 1'b1;
                    busy = BUSY_READS;
                    st = 3'd0;
                end
            end
            3'd2: begin
                if (pins.dq_out == 8'h20) begin
                    foreach (mem[k]) mem[k] = 8'hff;
                    prog = 1'b0;
                    busy = BUSY_READS;
                end
                st = (pins.dq_out == 8'hff) ? 3'd6 : 3'd0;
            end
            3'd3: begin
                if (pins.dq_out != 8'h60) flags = 8'h00;
                st = (pins.dq_out == 8'h60) ? 3'd4 : 3'd0;
                gap = GAP;
            end
            3'd4: gap = GAP;
            3'd6: st = 3'd0;
            default: case (pins.dq_out)
                8'h40: st = 3'd1;
                8'h20: st = 3'd2;
                8'h60: st = 3'd3;
                8'ha0: st = 3'd5;
                8'hff: st = 3'd6;
                default: st = 3'd0;
            endcase
        endcase
    end

    // Loading closes when no strobe starts within the gap
    always @(posedge mclk) begin
        if (st == 3'd4 && pins.we_n) begin
            gap--;
            if (gap == 0) begin
                foreach (mem[k]) if (flags[k[16:14]]) mem[k] = 8'hff;
                flags = 8'h00;
                prog = 1'b0;
                busy = BUSY_READS;
                st = 3'd0;
            end
        end
    end

    // Status reads while busy, array or verify data otherwise
    always @(negedge pins.oe_n) begin
        if (!hang && busy > 0) busy--;
        if (busy > 0) begin
            tog = ~tog;
            rd = {prog ? ~last[7] : 1'b0, tog, 6'h00};
        end else rd = mem[pins.addr];
    end

    // Released bus shows the inverse of the last byte
    assign dq_in = (!pins.ce_n && !pins.oe_n) ? rd : ~rd;
endmodule

// file: test/flash_command_state_machine_bench.sv
`timescale 1ns/1ps
module flash_command_state_machine_bench;
    logic                  mclk, rstn, req_valid, req_ready, done, fail, hang;
    flash_host_pkg::req_t  req;
    flash_host_pkg::pins_t pins;
    logic [7:0]            rdata, dq_in;
    logic [9:0]            expq [$];
    logic [9:0]            e;
    logic [7:0]            d [0:3];
    logic [16:0]           a [0:3];
    int                    mismatches, n_tests, cycles, i;
    integer                seed;

    flash_command_host #(.BLOCK_WAIT(24'd20), .POLL_LIMIT(24'd10)) i_dut (
        .mclk(mclk), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .done(done), .fail(fail), .rdata(rdata), .pins(pins), .dq_in(dq_in));
    flash_device_model i_flash (.mclk(mclk), .pins(pins), .hang(hang), .dq_in(dq_in));

    // Clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        if (expq.size() != 0) mismatches++;
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Issue one request; exp holds {check rdata, fail, rdata}
    task automatic run(input flash_host_pkg::op_t op, input logic [16:0] ad,
                       input logic [7:0] dt, input logic [7:0] bl, input logic [9:0] exp);
        while (req_ready !== 1'b1) begin
            @(posedge mclk);
            #1;
        end
        req_valid = 1'b1;
        req = '{op: op, addr: ad, data: dt, blocks: bl};
        expq.push_back(exp);
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
    endtask

    // Results are taken where done has settled
    always @(negedge mclk) begin
        if (done === 1'b1) begin
            if (expq.size() == 0) cmp_bit(1'b1, 1'b0);
            else begin
                e = expq.pop_front();
                cmp_bit(fail, e[8]);
                if (e[9]) cmp_byte(rdata, e[7:0]);
            end
        end
    end

    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test;
        end
    end

    initial begin
        seed = 32'h8a3adef3;
        rstn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        hang = 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        rstn = 1'b1;
        cmp_bit(pins.vpp_en, 1'b0);
        for (i = 0; i < 4; i++) begin
            a[i] = {3'(2 + i / 3), 12'($random(seed)), i[1:0]};
            d[i] = 8'($random(seed)) & 8'hfe;
            run(flash_host_pkg::OP_PROGRAM, a[i], d[i], 8'h00, 10'h000);
            run(flash_host_pkg::OP_READ, a[i], 8'h00, 8'h00, {2'b10, d[i]});
        end
        run(flash_host_pkg::OP_VERIFY, a[0], 8'h00, 8'h00, {2'b11, d[0]});
        run(flash_host_pkg::OP_VERIFY, 17'h14000, 8'h00, 8'h00, 10'h2ff);
        run(flash_host_pkg::OP_BLOCK_ERASE, 17'h0, 8'h00, 8'h24, 10'h000);
        run(flash_host_pkg::OP_READ, a[1], 8'h00, 8'h00, 10'h2ff);
        run(flash_host_pkg::OP_READ, a[3], 8'h00, 8'h00, {2'b10, d[3]});
        run(flash_host_pkg::OP_VERIFY, a[0], 8'h00, 8'h00, 10'h2ff);
        run(flash_host_pkg::OP_BLOCK_ERASE, 17'h0, 8'h00, 8'h00, 10'h100);
        run(flash_host_pkg::OP_RESET, 17'h0, 8'h00, 8'h00, 10'h000);
        run(flash_host_pkg::OP_READ_MODE, 17'h0, 8'h00, 8'h00, 10'h000);
        run(flash_host_pkg::OP_READ, a[3], 8'h00, 8'h00, {2'b10, d[3]});
        run(flash_host_pkg::OP_CHIP_ERASE, 17'h0, 8'h00, 8'h00, 10'h000);
        run(flash_host_pkg::OP_READ, a[3], 8'h00, 8'h00, 10'h2ff);
        hang = 1'b1;
        run(flash_host_pkg::OP_PROGRAM, a[0], d[0], 8'h00, 10'h100);
        while (req_ready !== 1'b1 || expq.size() != 0) @(posedge mclk);
        hang = 1'b0;
        run(flash_host_pkg::OP_PROGRAM, a[2], d[2], 8'h00, 10'h000);
        run(flash_host_pkg::OP_READ, a[2], 8'h00, 8'h00, {2'b10, d[2]});
        while (req_ready !== 1'b1 || expq.size() != 0) @(posedge mclk);
        stop_test;
    end
endmodule
